// ### design/bpo_top.sv
// bridge pwm output modes with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
// How it works
// - outputs change on the rising and falling strobes, dead-band expiry, direction swaps, disable and, in full-bridge mode, enable
// - complementary push-pull: primaries on a and b, complements on e and f
// - odd period: rise drops e, optional rise dead band, raises a; fall mirrors
// - even period: rise drops f, optional dead band, raises b; fall mirrors
// - four-output push-pull: a,c follow odd periods, b,d even, no dead band
// - six-output push-pull: a=c, b=d primaries, e and f complements
// - six-output odd period: e off, dead band, a and c on; fall mirrors
// - six-output even period: f off, dead band, b and d on; fall mirrors
// - pulse skipping: a only, rise only if an enabled qualifier was high at period
// - qualified rise comes from the timing strobe, fall is unqualified
// - complementary pulse skipping: primary on a, complement on b
// - complementary pulse skipping: b off, dead band, a on; fall mirrors
// - full-bridge mode uses a to d; direction comes from a control bit
// - forward to reverse uses falling dead band, reverse to forward rising
// - forward: d held on, b and c off, a follows rise and fall
// - reverse: c held on, a and d off, b follows rise and fall
module bpo_top
  import bpo_pkg::*;
#(
  parameter int SKIP_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire bpo_pkg::bpo_evt_s evt,
  input wire logic [SKIP_W-1:0] skip_in,
  output bpo_pkg::bpo_out_s bridge
);
  import bpo_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [5:0] outs;
    logic odd;
    logic seen;
    logic armed;
    logic [5:0] pend_r;
    logic [5:0] pend_f;
    logic rev;
    logic switching;
    logic en_d;
    logic [SKIP_W-1:0] s1;
    logic [SKIP_W-1:0] s2;
    logic [SKIP_W-1:0] s3;
    logic [SKIP_W-1:0] skip_f;
    logic [BPO_CTRL_W-1:0] ctrl;
    logic [BPO_DB_W-1:0] dbr;
    logic [BPO_DB_W-1:0] dbf;
    logic [SKIP_W-1:0] skip_en;
    logic aw_full;
    logic w_full;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bpo_st_s;

  bpo_st_s q;
  bpo_st_s next_q;

  logic start_r;
  logic start_f;
  logic cancel_r;
  logic cancel_f;
  logic busy_r;
  logic busy_f;
  logic done_r;
  logic done_f;

  // ==========================================================
  // dead-band counters
  bpo_dead_band #(.W(BPO_DB_W)) u_db_rise (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_r),
    .cancel(cancel_r),
    .load(q.dbr),
    .busy(busy_r),
    .done(done_r)
  );

  bpo_dead_band #(.W(BPO_DB_W)) u_db_fall (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_f),
    .cancel(cancel_f),
    .load(q.dbf),
    .busy(busy_f),
    .done(done_f)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] ws);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (ws[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] bit6(input int idx);
    logic [5:0] r;
    r = '0;
    r[idx] = 1'b1;
    return r;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] w32;
    logic [31:0] rd;
    logic rd_ok;
    logic en;
    logic par;
    logic use_db;
    logic rise_ok;
    logic [5:0] prim;
    logic [5:0] comp;
    bpo_mode_e mode;
    w32 = '0;
    rd = '0;
    rd_ok = 1'b1;
    en = q.ctrl[BPO_CTRL_EN];
    par = q.odd;
    use_db = 1'b0;
    rise_ok = 1'b1;
    prim = '0;
    comp = '0;
    mode = bpo_mode_e'(q.ctrl[BPO_CTRL_MODE_HI:BPO_CTRL_MODE_LO]);
    next_q = q;
    start_r = 1'b0;
    start_f = 1'b0;
    cancel_r = 1'b0;
    cancel_f = 1'b0;

    // qualifier inputs are asynchronous; only stage three and two are compared
    next_q.s1 = skip_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    if (q.s2 == q.s3) begin
      next_q.skip_f = q.s3;
    end

    // ----- write channel: address and data taken in either order
    if (awvalid && q.awready) begin
      next_q.aw_full = 1'b1;
      next_q.awa = awaddr;
    end
    if (wvalid && q.wready) begin
      next_q.w_full = 1'b1;
      next_q.wd = wdata;
      next_q.ws = wstrb;
    end
    if (q.bvalid && bready) begin
      next_q.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      next_q.aw_full = 1'b0;
      next_q.w_full = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = BPO_RESP_OKAY;
      unique case (q.awa)
        BPO_CTRL_ADDR: begin
          w32 = merge({25'h0, q.ctrl}, q.wd, q.ws);
          next_q.ctrl = w32[BPO_CTRL_W-1:0];
        end
        BPO_DBR_ADDR: begin
          w32 = merge({24'h0, q.dbr}, q.wd, q.ws);
          next_q.dbr = w32[BPO_DB_W-1:0];
        end
        BPO_DBF_ADDR: begin
          w32 = merge({24'h0, q.dbf}, q.wd, q.ws);
          next_q.dbf = w32[BPO_DB_W-1:0];
        end
        BPO_SKIP_ADDR: begin
          w32 = merge(32'(q.skip_en), q.wd, q.ws);
          next_q.skip_en = w32[SKIP_W-1:0];
        end
        BPO_STAT_ADDR: begin
          next_q.bresp = BPO_RESP_OKAY;
        end
        default: begin
          next_q.bresp = BPO_RESP_SLVERR;
        end
      endcase
    end
    next_q.awready = !next_q.aw_full && !next_q.bvalid;
    next_q.wready = !next_q.w_full && !next_q.bvalid;

    // ----- read channel
    if (q.rvalid && rready) begin
      next_q.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      unique case (araddr)
        BPO_CTRL_ADDR: rd = {25'h0, q.ctrl};
        BPO_DBR_ADDR: rd = {24'h0, q.dbr};
        BPO_DBF_ADDR: rd = {24'h0, q.dbf};
        BPO_SKIP_ADDR: rd = 32'(q.skip_en);
        BPO_STAT_ADDR: begin
          rd[5:0] = q.outs;
          rd[BPO_ST_ODD] = q.odd;
          rd[BPO_ST_ARMED] = q.armed;
          rd[BPO_ST_RBUSY] = busy_r;
          rd[BPO_ST_FBUSY] = busy_f;
          rd[BPO_ST_REV] = q.rev;
          rd[BPO_ST_SWITCH] = q.switching;
        end
        default: rd_ok = 1'b0;
      endcase
      next_q.rvalid = 1'b1;
      next_q.rdata = rd;
      next_q.rresp = rd_ok ? BPO_RESP_OKAY : BPO_RESP_SLVERR;
    end
    next_q.arready = !next_q.rvalid;

    // ----- waveform generation
    next_q.en_d = en;
    if (!en || !q.en_d) begin
      // disabled, or first enabled cycle: all off, period count restarts
      next_q.outs = '0;
      next_q.pend_r = '0;
      next_q.pend_f = '0;
      next_q.seen = 1'b0;
      next_q.odd = 1'b1;
      next_q.armed = 1'b0;
      next_q.switching = 1'b0;
      next_q.rev = q.ctrl[BPO_CTRL_REV];
      cancel_r = 1'b1;
      cancel_f = 1'b0 | 1'b1;
    end else begin
      // the first period event opens period one, later ones alternate
      if (evt.period) begin
        par = q.seen ? !q.odd : 1'b1;
        next_q.seen = 1'b1;
        next_q.odd = par;
        next_q.armed = |(q.skip_f & q.skip_en);
      end

      unique case (mode)
        BPO_MODE_PP_COMP: begin
          prim = par ? bit6(BPO_A) : bit6(BPO_B);
          comp = par ? bit6(BPO_E) : bit6(BPO_F);
          use_db = 1'b1;
        end
        BPO_MODE_PP_FULL4: begin
          // bridge_out_0/2 are a/c, bridge_out_1/3 are b/d
          prim = par ? (bit6(BPO_A) | bit6(BPO_C))
                     : (bit6(BPO_B) | bit6(BPO_D));
        end
        BPO_MODE_PP_SIX: begin
          prim = par ? (bit6(BPO_A) | bit6(BPO_C))
                     : (bit6(BPO_B) | bit6(BPO_D));
          comp = par ? bit6(BPO_E) : bit6(BPO_F);
          use_db = 1'b1;
        end
        BPO_MODE_SKIP: begin
          prim = bit6(BPO_A);
          rise_ok = q.armed;
        end
        BPO_MODE_SKIP_COMP: begin
          prim = bit6(BPO_A);
          comp = bit6(BPO_B);
          use_db = 1'b1;
          rise_ok = q.armed;
        end
        BPO_MODE_FBRIDGE: begin
          prim = q.rev ? bit6(BPO_B) : bit6(BPO_A);
        end
        default: begin
          prim = '0;
        end
      endcase

      // dead-band expiry turns on whatever was waiting for it
      if (done_r) begin
        next_q.outs = next_q.outs | q.pend_r;
        next_q.pend_r = '0;
      end
      if (done_f) begin
        next_q.outs = next_q.outs | q.pend_f;
        next_q.pend_f = '0;
      end
      if (q.switching && (done_r || done_f)) begin
        next_q.switching = 1'b0;
        next_q.rev = !q.rev;
      end

      if (mode == BPO_MODE_FBRIDGE && !q.switching
          && q.ctrl[BPO_CTRL_REV] != q.rev) begin
        // direction swap: everything off, then the new static leg after dead band
        next_q.outs = '0;
        if (!q.rev) begin
          if (q.ctrl[BPO_CTRL_DBF_EN]) begin
            start_f = 1'b1;
            next_q.pend_f = bit6(BPO_C);
            next_q.switching = 1'b1;
          end else begin
            next_q.rev = 1'b1;
          end
        end else begin
          if (q.ctrl[BPO_CTRL_DBR_EN]) begin
            start_r = 1'b1;
            next_q.pend_r = bit6(BPO_D);
            next_q.switching = 1'b1;
          end else begin
            next_q.rev = 1'b0;
          end
        end
      end else if (!q.switching) begin
        if (evt.rise && rise_ok) begin
          next_q.outs = next_q.outs & ~comp;
          next_q.armed = evt.period && next_q.armed; // a same-cycle period re-arm wins
          if (use_db && q.ctrl[BPO_CTRL_DBR_EN]) begin
            start_r = 1'b1;
            next_q.pend_r = prim;
          end else begin
            next_q.outs = next_q.outs | prim;
          end
        end
        if (evt.fall) begin
          // a fall cancels a rise still waiting out its dead band
          next_q.outs = next_q.outs & ~prim;
          next_q.pend_r = '0;
          cancel_r = !start_r;
          if (use_db && q.ctrl[BPO_CTRL_DBF_EN]) begin
            start_f = 1'b1;
            next_q.pend_f = comp;
          end else begin
            next_q.outs = next_q.outs | comp;
          end
        end
        if (mode == BPO_MODE_FBRIDGE) begin
          if (!next_q.rev) begin
            next_q.outs[BPO_D] = 1'b1;
            next_q.outs[BPO_B] = 1'b0;
            next_q.outs[BPO_C] = 1'b0;
          end else begin
            next_q.outs[BPO_C] = 1'b1;
            next_q.outs[BPO_A] = 1'b0;
            next_q.outs[BPO_D] = 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= BPO_CTRL_RST;
      q.dbr <= BPO_DB_RST;
      q.dbf <= BPO_DB_RST;
      q.odd <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign bridge = bpo_out_s'(q.outs);
endmodule // bpo_top

// ### pkg/bpo_pkg.sv
// shared constants, modes and carriers of the bridge pwm output block
package bpo_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] BPO_CTRL_ADDR = 8'h00;
  localparam logic [7:0] BPO_DBR_ADDR = 8'h04;
  localparam logic [7:0] BPO_DBF_ADDR = 8'h08;
  localparam logic [7:0] BPO_SKIP_ADDR = 8'h0C;
  localparam logic [7:0] BPO_STAT_ADDR = 8'h10;

  // ==========================================================
  // control fields
  localparam int BPO_CTRL_EN = 0;
  localparam int BPO_CTRL_MODE_LO = 1;
  localparam int BPO_CTRL_MODE_HI = 3;
  localparam int BPO_CTRL_DBR_EN = 4;
  localparam int BPO_CTRL_DBF_EN = 5;
  localparam int BPO_CTRL_REV = 6;
  localparam int BPO_CTRL_W = 7;
  localparam logic [6:0] BPO_CTRL_RST = 7'h00;
  localparam int BPO_DB_W = 8;
  localparam logic [7:0] BPO_DB_RST = 8'h00;

  // ==========================================================
  // status fields
  localparam int BPO_ST_ODD = 6;
  localparam int BPO_ST_ARMED = 7;
  localparam int BPO_ST_RBUSY = 8;
  localparam int BPO_ST_FBUSY = 9;
  localparam int BPO_ST_REV = 10;
  localparam int BPO_ST_SWITCH = 11;

  // ==========================================================
  // output bit positions in the six-wide output vector
  localparam int BPO_A = 0;
  localparam int BPO_B = 1;
  localparam int BPO_C = 2;
  localparam int BPO_D = 3;
  localparam int BPO_E = 4;
  localparam int BPO_F = 5;

  localparam logic [1:0] BPO_RESP_OKAY = 2'h0;
  localparam logic [1:0] BPO_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    BPO_MODE_PP_COMP,
    BPO_MODE_PP_FULL4,
    BPO_MODE_PP_SIX,
    BPO_MODE_SKIP,
    BPO_MODE_SKIP_COMP,
    BPO_MODE_FBRIDGE
  } bpo_mode_e;

  typedef struct packed {
    logic period;
    logic rise;
    logic fall;
  } bpo_evt_s;

  typedef struct packed {
    logic out_f;
    logic out_e;
    logic out_d;
    logic out_c;
    logic out_b;
    logic out_a;
  } bpo_out_s;

endpackage

// ### design/bpo_dead_band.sv
// one dead-band delay counter
`timescale 1ns/10ps
module bpo_dead_band
  import bpo_pkg::*;
#(
  parameter int W = BPO_DB_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } bpo_db_s;

  bpo_db_s q;
  bpo_db_s next_q;

  // a load of n ends n+1 cycles after start, so zero still separates the edges
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (cancel) begin
      next_q.busy = 1'b0;
    end else if (start) begin
      next_q.busy = 1'b1;
      next_q.cnt = load;
    end else if (q.busy) begin
      if (q.cnt == '0) begin
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
      end else begin
        next_q.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign busy = q.busy;
  assign done = q.done;
endmodule // bpo_dead_band

// ### dv/bpo_switch_model.sv
// model of the external bridge switch drivers, counting shoot-through
`timescale 1ns/10ps
module bpo_switch_model
  import bpo_pkg::*;
(
  input wire logic aclk,
  input wire bpo_pkg::bpo_out_s bridge,
  output logic [7:0] faults
);
  // ==========================================================
  // legs that share a rail must never conduct together
  initial faults = 8'h00;
  always @(posedge aclk) begin
    if ((bridge.out_a && bridge.out_e) || (bridge.out_b && bridge.out_f) ||
        (bridge.out_c && bridge.out_d) || (bridge.out_a && bridge.out_b)) begin
      faults <= faults + 8'h01;
    end
  end
endmodule // bpo_switch_model

// ### dv/bpo_top_monitor.sv
// concurrent checks on the ports of the bridge pwm output block
`timescale 1ns/10ps
module bpo_top_chk
  import bpo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire bpo_pkg::bpo_out_s bridge
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // register bus
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    bridge == '0 && !awready && !bvalid && !rvalid) else $error("not idle in reset");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered next cycle");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write not answered");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  // ==========================================================
  // output legs; a slip in pairing or dead band shows as overlap
  a_ae_apart: assert property (!(bridge.out_a && bridge.out_e))
    else $error("a and e active together");
  a_bf_apart: assert property (!(bridge.out_b && bridge.out_f))
    else $error("b and f active together");
  a_cd_apart: assert property (!(bridge.out_c && bridge.out_d))
    else $error("c and d active together");
  a_ab_apart: assert property (!(bridge.out_a && bridge.out_b))
    else $error("a and b active together");
endmodule // bpo_top_chk
bind bpo_top bpo_top_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .bridge(bridge));

// ### dv/testbench.sv
// self-checking bench for the bridge pwm output block
`timescale 1ns/10ps
module testbench;
  import bpo_pkg::*;
  localparam bpo_evt_s EP = 3'h4;
  localparam bpo_evt_s ER = 3'h2;
  localparam bpo_evt_s EF = 3'h1;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, faults;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] skip_in = 4'h0;
  bpo_evt_s evt = '0;
  bpo_out_s bridge;
  int fails = 0, samples_checked = 0;
  always #5 aclk = ~aclk;
  bpo_top #(.SKIP_W(4)) dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .evt(evt), .skip_in(skip_in),
    .bridge(bridge));
  bpo_switch_model sw_u (.aclk(aclk), .bridge(bridge), .faults(faults));
  // ==========================================================
  // shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang();
    fails++;
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (n > 100) hang();
    end while (!(bready && bvalid === 1'b1));
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (n > 100) hang();
    end while (!(rready && rvalid === 1'b1));
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // one strobe, then the levels right after the edge that took it
  task automatic ev(input bpo_evt_s e, input logic [5:0] x);
    @(posedge aclk);
    evt <= e;
    @(posedge aclk);
    evt <= '0;
    #1;
    chk("bridge", 32'(bridge), 32'(x));
  endtask
  // delayed leg turns on load+2 edges after the event edge
  task automatic late(input logic [5:0] b, input logic [5:0] a);
    repeat (3) @(posedge aclk);
    #1;
    chk("bridge before dead band", 32'(bridge), 32'(b));
    @(posedge aclk);
    #1;
    chk("bridge after dead band", 32'(bridge), 32'(a));
  endtask
  // re-enable restarts the period count at odd
  task automatic go(input bpo_mode_e m, input logic [2:0] x);
    wr(BPO_CTRL_ADDR, 32'h0);
    wr(BPO_CTRL_ADDR, {25'h0, x, m, 1'b1});
    repeat (3) @(posedge aclk);
  endtask
  task automatic arm(input logic [3:0] q);
    @(posedge aclk);
    skip_in <= q;
    repeat (5) @(posedge aclk);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_regs();
    logic [31:0] d;
    rd(BPO_CTRL_ADDR, d);
    chk("ctrl reset", d, 32'h0);
    wr(BPO_DBR_ADDR, 32'hFFFF_FFA5);
    rd(BPO_DBR_ADDR, d);
    chk("dbr", d, 32'h0000_00A5);
    wr(8'h40, 32'h1);
    chk("bresp unmapped", 32'(resp), 32'(BPO_RESP_SLVERR));
    rd(8'h40, d);
    chk("rresp unmapped", 32'(resp), 32'(BPO_RESP_SLVERR));
    chk("rdata unmapped", d, 32'h0);
    // status is read-only: the write is answered but changes nothing
    wr(BPO_STAT_ADDR, 32'hFFF);
    chk("bresp status", 32'(resp), 32'(BPO_RESP_OKAY));
    rd(BPO_STAT_ADDR, d);
    chk("status idle", d, 32'h40);
    ev(ER, 6'h00);
  endtask
  task automatic s_pp_comp();
    go(BPO_MODE_PP_COMP, 3'h0);
    ev(EP, 6'h00);
    ev(ER, 6'h01);
    ev(EF, 6'h10);
    ev(EP, 6'h10);
    ev(ER, 6'h12);
    ev(EF, 6'h30);
    ev(EP, 6'h30);
    ev(ER, 6'h21);
    ev(EF, 6'h30);
  endtask
  task automatic s_six();
    logic [31:0] d;
    wr(BPO_DBR_ADDR, 32'h2);
    go(BPO_MODE_PP_SIX, 3'h1);
    ev(EP, 6'h00);
    ev(ER, 6'h00);
    late(6'h00, 6'h05);
    ev(EF, 6'h10);
    ev(EP, 6'h10);
    ev(ER, 6'h10);
    late(6'h10, 6'h1A);
    ev(EF, 6'h30);
    ev(EP, 6'h30);
    ev(ER, 6'h20);
    late(6'h20, 6'h25);
    rd(BPO_STAT_ADDR, d);
    chk("status", d, 32'h65);
  endtask
  task automatic s_full4();
    go(BPO_MODE_PP_FULL4, 3'h0);
    ev(EP, 6'h00);
    ev(ER, 6'h05);
    ev(EF, 6'h00);
    ev(EP, 6'h00);
    ev(ER, 6'h0A);
    ev(EF, 6'h00);
  endtask
  task automatic s_skip();
    wr(BPO_SKIP_ADDR, 32'h1);
    go(BPO_MODE_SKIP, 3'h0);
    ev(EP, 6'h00);
    ev(ER, 6'h00);
    arm(4'h2);
    ev(EP, 6'h00);
    ev(ER, 6'h00);
    arm(4'h1);
    ev(EP, 6'h00);
    arm(4'h0);
    ev(ER, 6'h01);
    ev(EF, 6'h00);
    ev(EP, 6'h00);
    ev(ER, 6'h00);
    ev(EF, 6'h00);
    go(BPO_MODE_SKIP_COMP, 3'h0);
    arm(4'h1);
    ev(EP, 6'h00);
    ev(ER, 6'h01);
    ev(EF, 6'h02);
  endtask
  // direction swap: all off, new static leg n+2 edges after the edge that starts it
  task automatic swap(input logic [2:0] x, input int n, input logic [5:0] leg);
    wr(BPO_CTRL_ADDR, {25'h0, x, BPO_MODE_FBRIDGE, 1'b1});
    repeat (n + 1) @(posedge aclk);
    #1;
    chk("bridge in swap", 32'(bridge), 32'h0);
    @(posedge aclk);
    #1;
    chk("bridge after swap", 32'(bridge), 32'(leg));
    repeat (10) @(posedge aclk);
  endtask
  task automatic s_fbridge();
    wr(BPO_DBF_ADDR, 32'h3);
    go(BPO_MODE_FBRIDGE, 3'h2);
    ev(EP, 6'h08);
    ev(ER, 6'h09);
    ev(EF, 6'h08);
    // forward to reverse waits out the falling counter, loaded with 3
    swap(3'h6, 3, 6'h04);
    ev(EP, 6'h04);
    ev(ER, 6'h06);
    ev(EF, 6'h04);
    // reverse to forward waits out the rising counter, loaded with 2
    swap(3'h3, 2, 6'h08);
    ev(EP, 6'h08);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_regs();
    s_pp_comp();
    s_six();
    s_full4();
    s_skip();
    s_fbridge();
    chk("driver faults", 32'(faults), 32'h0);
    complete_run();
  end
  initial begin
    #500000;
    hang();
  end
endmodule // testbench
